// File: hw/aem_pkg.sv
package aem_pkg;
  // Number of supervised axes (X, Y, Z, E and one spare drive-enable line).
  localparam int NUM_AXES = 5;
  // Error code issued when a traverse needs a prior reference approach.
  localparam logic [7:0] ERR_FUNC_DISABLED = 8'hEB;
  // Error code value meaning no error.
  localparam logic [7:0] ERR_NONE = 8'h00;
  // Operating modes as presented by the controller.
  typedef enum logic [1:0] {
    AEM_MODE_IDLE = 2'h0,
    AEM_MODE_AUTO = 2'h1,
    AEM_MODE_JOG = 2'h3,
    AEM_MODE_BLOCK = 2'h2
  } aem_mode_t;
  // Scan-cycle state of the bypass latch, Gray ordered.
  typedef enum logic [1:0] {
    AEM_BYP_OFF = 2'h0,
    AEM_BYP_ARMED = 2'h1,
    AEM_BYP_ON = 2'h3
  } aem_byp_state_t;
endpackage

// File: hw/aem_axis_if.sv
`timescale 1ns/1ps
// Per-axis supervision state passed from the top to the motion checker.
interface aem_axis_if #(parameter int N = aem_pkg::NUM_AXES);
  // Encoder supervision switched off for this axis.
  logic [N-1:0] unsup;
  // Axis has completed a reference approach.
  logic [N-1:0] refd;
  // Warning and error flags per axis from the checker.
  logic [N-1:0] warn;
  logic [N-1:0] err;
  modport top (output unsup, output refd, input warn, input err);
  modport chk (input unsup, input refd, output warn, output err);
endinterface

// File: hw/aem_motion_check.sv
`timescale 1ns/1ps
// Combinational classification of a traverse on unsupervised axes.
module aem_motion_check #(
  parameter int N = aem_pkg::NUM_AXES
) (
  // Axis state.
  aem_axis_if.chk ax,
  // Traverse request context.
  input wire logic [N-1:0] i_move,
  input wire logic i_swlim_on,
  input wire aem_pkg::aem_mode_t i_mode
);
  // One flag per axis keeps each message tied to its own axis.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ax
      always_comb begin
        ax.warn[g] = 1'b0;
        ax.err[g] = 1'b0;
        if (ax.unsup[g] && i_move[g]) begin
          if (!i_swlim_on) begin
            // Any active mode gives the measuring-system warning.
            ax.warn[g] = (i_mode != aem_pkg::AEM_MODE_IDLE);
          end else if (i_mode == aem_pkg::AEM_MODE_JOG) begin
            ax.warn[g] = 1'b1;
          end else if (i_mode == aem_pkg::AEM_MODE_AUTO ||
                       i_mode == aem_pkg::AEM_MODE_BLOCK) begin
            // A referenced axis may still be traversed.
            ax.err[g] = !ax.refd[g];
          end
        end
      end
    end
  endgenerate
endmodule

// File: hw/aem_top.sv
`timescale 1ns/1ps
// Contract
// - Supervision off only with bypass and drive low.
// - Bypass acts after current scan cycle ends.
// - Drive enable rising resumes supervision immediately.
// - Bypass release clears all pending alarms.
// - Disconnected encoder alarms unless bypassed and disabled.
// - Reference approach allowed while supervision off.
// - Limits off, any active mode traverse warns.
// - Limits on, jog traverse also warns.
// - Limits on, programmed traverse needs reference.
// - Every warning or error names its axis.
// - Bypass level shown as last status entry.
module aem_top #(
  parameter int N = aem_pkg::NUM_AXES,
  parameter int STAT_W = 8
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Controller interface.
  input wire logic i_bypass,
  input wire logic i_scan_end,
  input wire logic [N-1:0] i_drive_en,
  // Encoder connection status from the axes.
  input wire logic [N-1:0] i_enc_ok,
  // Motion context.
  input wire logic [N-1:0] i_move,
  input wire logic [N-1:0] i_ref_move,
  input wire logic [N-1:0] i_ref_done,
  input wire logic i_swlim_on,
  input wire aem_pkg::aem_mode_t i_mode,
  // Other input levels for the status list.
  input wire logic [STAT_W-2:0] i_status_in,
  // Results.
  output logic [N-1:0] o_supervised,
  output logic [N-1:0] o_alarm,
  output logic [N-1:0] o_warn,
  output logic [N-1:0] o_err,
  output logic [7:0] o_err_code,
  output logic [N-1:0] o_ref_allowed,
  output logic [STAT_W-1:0] o_status
);
  // Whole module state in one record.
  typedef struct packed {
    logic [2:0] byp_sync;
    logic [2:0] scan_sync;
    logic byp_q;
    aem_pkg::aem_byp_state_t byp_st;
    logic [N-1:0] refd;
    logic [N-1:0] sup;
    logic [N-1:0] alarm;
    logic [N-1:0] warn;
    logic [N-1:0] err;
    logic [7:0] err_code;
    logic [N-1:0] ref_ok;
    logic [STAT_W-1:0] status;
  } aem_state_t;

  aem_state_t st;
  aem_state_t next_st;
  // Bypass level accepted by the synchroniser.
  logic byp_lvl;
  // Scan end accepted as a level.
  logic scan_lvl;
  // Bypass effective for supervision decisions.
  logic byp_eff;
  aem_axis_if #(.N(N)) ax ();

  // Axis state handed to the checker.
  assign ax.unsup = ~st.sup;
  assign ax.refd = st.refd;

  aem_motion_check #(.N(N)) u_check (
    .ax(ax),
    .i_move(i_move),
    .i_swlim_on(i_swlim_on),
    .i_mode(i_mode)
  );

  // A bypass change counts only once the second and third stages agree; scan end needs both stages high.
  always_comb begin
    byp_lvl = (st.byp_sync[1] == st.byp_sync[2]) ? st.byp_sync[2] : st.byp_q;
    scan_lvl = st.scan_sync[1] & st.scan_sync[2];
    byp_eff = (st.byp_st == aem_pkg::AEM_BYP_ON);
  end

  // Next-state logic.
  always_comb begin
    next_st = st;
    next_st.byp_sync = {st.byp_sync[1:0], i_bypass};
    next_st.scan_sync = {st.scan_sync[1:0], i_scan_end};
    next_st.byp_q = byp_lvl;
    // A set request waits for the scan boundary, a release acts at once.
    case (st.byp_st)
      aem_pkg::AEM_BYP_OFF: begin
        if (byp_lvl) begin
          next_st.byp_st = aem_pkg::AEM_BYP_ARMED;
        end
      end
      aem_pkg::AEM_BYP_ARMED: begin
        if (!byp_lvl) begin
          next_st.byp_st = aem_pkg::AEM_BYP_OFF;
        end else if (scan_lvl) begin
          next_st.byp_st = aem_pkg::AEM_BYP_ON;
        end
      end
      aem_pkg::AEM_BYP_ON: begin
        if (!byp_lvl) begin
          next_st.byp_st = aem_pkg::AEM_BYP_OFF;
        end
      end
      default: begin
        next_st.byp_st = aem_pkg::AEM_BYP_OFF;
      end
    endcase
    // Supervision drops only for disabled drives; an enabled drive resumes it.
    next_st.sup = ~({N{byp_eff}} & ~i_drive_en);
    // Reference completion is remembered per axis.
    next_st.refd = st.refd | i_ref_done;
    // Reference approach stays permitted regardless of supervision.
    next_st.ref_ok = i_ref_move;
    // Alarms set for missing encoders on supervised axes and stay latched.
    if (st.byp_q && !byp_lvl) begin
      next_st.alarm = '0;
    end else begin
      next_st.alarm = st.alarm | (st.sup & ~i_enc_ok);
    end
    next_st.warn = ax.warn;
    next_st.err = ax.err;
    next_st.err_code = (|ax.err) ? aem_pkg::ERR_FUNC_DISABLED : aem_pkg::ERR_NONE;
    // Bypass level sits in the top bit, the last entry of the list.
    next_st.status = {byp_lvl, i_status_in};
  end

  // State register.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '{byp_st: aem_pkg::AEM_BYP_OFF, sup: '1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops.
  assign o_supervised = st.sup;
  assign o_alarm = st.alarm;
  assign o_warn = st.warn;
  assign o_err = st.err;
  assign o_err_code = st.err_code;
  assign o_ref_allowed = st.ref_ok;
  assign o_status = st.status;

  // Assertions.
  // A release seen by the synchroniser: the level fell while the last accepted one was high.
  sequence s_release;
    !byp_lvl && st.byp_q;
  endsequence

  // Bypass not yet effective and no synchronised scan end in this cycle.
  sequence s_set_waiting;
    st.byp_st != aem_pkg::AEM_BYP_ON && !scan_lvl;
  endsequence

  // Every pending alarm is gone one cycle after a release.
  chk_release_clears: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    s_release |=> st.alarm == '0)
    else $error("alarms not cleared on release");

  // An axis whose drive was enabled is supervised in the next cycle, bypass or not.
  chk_enabled_stays_sup: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    1'b1 |=> (st.sup & $past(i_drive_en)) == $past(i_drive_en))
    else $error("enabled axis lost supervision");

  // Without an effective bypass no axis may lose supervision.
  chk_no_bypass_sup: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    !byp_eff |=> &st.sup)
    else $error("axis unsupervised without bypass");

  // A drive that comes on under an effective bypass is supervised at once.
  chk_resume_now: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    byp_eff && (|(i_drive_en & ~$past(i_drive_en))) |=>
      (st.sup & $past(i_drive_en)) == $past(i_drive_en))
    else $error("supervision did not resume");

  // The bypass can only become effective from a synchronised scan end.
  chk_wait_scan: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    s_set_waiting |=> st.byp_st != aem_pkg::AEM_BYP_ON)
    else $error("bypass skipped scan wait");

  // While the bypass level stands no alarm may drop.
  chk_alarm_latch: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    byp_lvl |=> (st.alarm & $past(st.alarm)) == $past(st.alarm))
    else $error("alarm dropped");

  // A missing encoder on supervised axis 0 raises its alarm unless a release clears it.
  chk_alarm_set: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    st.sup[0] && !i_enc_ok[0] && !(st.byp_q && !byp_lvl) |=> st.alarm[0])
    else $error("missing alarm");

  // Any per-axis error carries the function-disabled code.
  chk_err_code: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    |st.err |-> st.err_code == aem_pkg::ERR_FUNC_DISABLED)
    else $error("bad error code");

  // The last status entry follows the accepted bypass level.
  chk_status_last: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    ##1 st.status[STAT_W-1] == $past(byp_lvl))
    else $error("status bit wrong");

  // A reference approach is passed on for every axis, supervised or not.
  chk_ref_allowed: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    1'b1 |=> st.ref_ok == $past(i_ref_move))
    else $error("reference blocked");
endmodule

// File: test/aem_plc_model.sv
`timescale 1ns/1ps
// Controller model: it ends one scan every eight cycles while it runs.
module aem_plc_model (
  // Clock, reset and run enable.
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_run,
  // Scan complete marker.
  output logic o_scan_end
);
  logic [2:0] cnt; // Scan phase counter.
  // The counter free-runs, so the scan phase stays unrelated to the bench's requests.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
  // The marker stands for two cycles, because one cycle could slip past the synchroniser.
  assign o_scan_end = i_run && (cnt >= 3'h6);
endmodule

// File: test/aem_top_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the encoder supervision bypass.
module aem_top_bench;
  logic clk, rst_n, byp, run, scan, swl; // Clock, reset and single-bit controls.
  logic [4:0] drv, enc, mv, refm, refd, sup, alm, wrn, err, refa; // Per-axis vectors.
  logic [6:0] stat_in; // Other status levels.
  logic [7:0] code, stat; // Error code and status list.
  aem_pkg::aem_mode_t mode; // Operating mode.
  aem_pkg::aem_mode_t modes [3] = '{aem_pkg::AEM_MODE_AUTO, aem_pkg::AEM_MODE_JOG,
    aem_pkg::AEM_MODE_BLOCK}; // Every traversing mode.
  int err_total = 0; // Mismatches found.
  int compares = 0; // Comparisons made.
  aem_top i_aem_top (.i_clk_sys(clk), .i_reset_n(rst_n), .i_bypass(byp), .i_scan_end(scan),
    .i_drive_en(drv), .i_enc_ok(enc), .i_move(mv), .i_ref_move(refm), .i_ref_done(refd),
    .i_swlim_on(swl), .i_mode(mode), .i_status_in(stat_in), .o_supervised(sup),
    .o_alarm(alm), .o_warn(wrn), .o_err(err), .o_err_code(code), .o_ref_allowed(refa),
    .o_status(stat));
  aem_plc_model i_aem_plc_model (.i_clk_sys(clk), .i_reset_n(rst_n), .i_run(run),
    .o_scan_end(scan));
  // The clock runs at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Waits a number of rising edges.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Cuts a hang short well after the tests should have ended.
  initial begin
    #100000;
    err_total++;
    tally_and_finish;
  end
  // Main sequence.
  initial begin
    {rst_n, byp, run, swl} = 4'h0;
    {drv, mv, refm, refd} = 20'h00000;
    enc = 5'h1F;
    stat_in = 7'h55;
    mode = aem_pkg::AEM_MODE_IDLE;
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
    chk(sup, 8'h1F, "supervised after reset");
    drv <= 5'h03;
    byp <= 1'b1;
    cyc(12);
    chk(sup, 8'h1F, "bypass acted without scan end");
    run <= 1'b1;
    cyc(20);
    chk(sup, 8'h03, "bypass not applied");
    chk(stat, 8'hD5, "status list");
    drv <= 5'h07;
    cyc(2);
    chk(sup, 8'h07, "drive enable did not resume");
    $display("test bypass done");
    // Axis 0 is supervised and axis 3 is bypassed; only axis 0 may alarm.
    enc <= 5'h16;
    cyc(3);
    enc <= 5'h1F;
    cyc(3);
    chk(alm, 8'h01, "alarm wrong or not latched");
    mv <= 5'h10;
    for (int k = 0; k < 3; k++) begin
      mode <= modes[k];
      cyc(2);
      chk(wrn, 8'h10, "warning with limits off");
    end
    swl <= 1'b1;
    mode <= aem_pkg::AEM_MODE_JOG;
    cyc(2);
    chk(wrn, 8'h10, "jog warning with limits on");
    mode <= aem_pkg::AEM_MODE_AUTO;
    cyc(2);
    chk(err, 8'h10, "error flag");
    chk(code, aem_pkg::ERR_FUNC_DISABLED, "error code");
    chk(wrn, 8'h00, "warning in auto with limits on");
    mode <= aem_pkg::AEM_MODE_BLOCK;
    cyc(2);
    chk(err, 8'h10, "error flag in block entry mode");
    refm <= 5'h10;
    cyc(2);
    chk(refa, 8'h10, "reference approach refused");
    refd <= 5'h10;
    cyc(1);
    refd <= 5'h00;
    cyc(2);
    chk(err, 8'h00, "error after reference");
    chk(code, aem_pkg::ERR_NONE, "code after reference");
    $display("test motion done");
    mv <= 5'h00;
    byp <= 1'b0;
    cyc(8);
    chk(alm, 8'h00, "alarm not cleared on release");
    chk(sup, 8'h1F, "supervision after release");
    $display("test release done");
    // Axis 0 alarms again, and a reset in mid-run must clear it.
    enc <= 5'h1E;
    cyc(2);
    chk(alm, 8'h01, "alarm before reset");
    enc <= 5'h1F;
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    chk(alm, 8'h00, "alarm not cleared by reset");
    chk(sup, 8'h1F, "supervised after second reset");
    $display("test reset done");
    tally_and_finish;
  end
endmodule
